/* logic/ofs_pkg.sv */
// shared constants and types of the fir output scale and sync block
`default_nettype none
package ofs_pkg;
    // register indices; byte address is four times the index
    localparam logic [11:0] REG_MODE_CONTROL = 12'h0300;
    localparam logic [11:0] REG_COMB_TWO_DECIMATION = 12'h0306;
    localparam logic [11:0] REG_COMB_FIVE_DECIMATION = 12'h0308;
    localparam logic [11:0] REG_OUTPUT_SCALE_CONTROL = 12'h0309;
    localparam logic [11:0] REG_FIR_DECIMATION = 12'h030a;
    localparam logic [11:0] REG_COEFFICIENT_START_OFFSET = 12'h030b;
    localparam logic [11:0] REG_TAP_COUNT = 12'h030c;
    localparam logic [11:0] REG_OUTPUT_FORMAT = 12'h030e;
    localparam logic [11:0] REG_BLOCK_STATUS = 12'h030f;
    localparam int APB_ADDR_W = 14;
    // mode control fields
    localparam int MODE_SOFT_RESET_BIT = 0;
    localparam int MODE_DUAL_CHANNEL_BIT = 1;
    localparam int MODE_SYNC_MASTER_BIT = 3;
    localparam logic [3:0] MODE_CONTROL_RESET = 4'h1;
    // output scale control fields
    localparam int SCALE_LSB = 0;
    localparam int SCALE_W = 3;
    localparam int UNIQUE_B_BIT = 3;
    localparam logic [3:0] OUTPUT_SCALE_RESET = 4'h0;
    localparam logic [7:0] BYTE_REG_RESET = 8'h00;
    // scaler arithmetic
    localparam int FIR_RESULT_W = 23;
    localparam int PORT_WORD_W = 32;
    localparam int SCALE_UNITY = 4;
    localparam int ROUND_DROP_BITS = 7;
    // cycles from the master comb counter reaching zero to the counter load edge
    localparam int SYNC_LAT = 4;
    typedef enum logic [1:0] {
        OFS_FMT_16 = 2'h0,
        OFS_FMT_24 = 2'h1,
        OFS_FMT_32 = 2'h2
    } ofs_fmt_t;
    localparam logic [1:0] OUTPUT_FORMAT_RESET = 2'h0;
    // coefficient step handed to the mac datapath
    typedef struct packed {
        logic valid;
        logic chan_b;
        logic first;
        logic last;
        logic [7:0] addr;
    } ofs_coef_step_t;
    // sync pad pair, one bit per pin
    typedef struct packed {
        logic comb;
        logic fir;
    } ofs_sync_pins_t;
endpackage
`default_nettype wire

/* logic/ofs_phase_cnt.sv */
// decimation phase counter with realignment load
`default_nettype none
module ofs_phase_cnt #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic hold,
    input wire logic advance,
    input wire logic [W-1:0] last,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    // state
    output logic [W-1:0] count,
    output logic at_zero
);
    logic [W-1:0] count_ff;

    if (W < 2) begin : g_chk
        $error("ofs_phase_cnt: W too small");
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= '0;
        end else if (hold) begin
            count_ff <= '0;
        end else if (load) begin
            count_ff <= load_val;
        end else if (advance) begin
            count_ff <= (count_ff >= last) ? '0 : count_ff + 1'b1;
        end
    end

    assign count = count_ff;
    assign at_zero = (count_ff == '0);
endmodule
`default_nettype wire

/* logic/ofs_scaler.sv */
// output scaling, rounding and saturation of the fir result
`default_nettype none
module ofs_scaler
    import ofs_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // fir result
    input wire logic in_valid,
    input wire logic [ofs_pkg::FIR_RESULT_W-1:0] in_word,
    input wire logic [ofs_pkg::SCALE_W-1:0] scale,
    input wire ofs_pkg::ofs_fmt_t fmt,
    // port word
    output logic out_valid,
    output logic [ofs_pkg::PORT_WORD_W-1:0] out_word
);
    import ofs_pkg::*;
    logic out_valid_ff;
    logic [PORT_WORD_W-1:0] out_word_ff;
    logic [PORT_WORD_W-1:0] nxt_out_word;

    // shift by 3+scale, ties away, saturate
    function automatic logic [15:0] round16(input logic [FIR_RESULT_W-1:0] x, input logic [SCALE_W-1:0] s);
        logic signed [25:0] xs;
        logic signed [25:0] bias;
        logic signed [25:0] sum;
        int unsigned rs;
        xs = 26'(signed'(x));
        rs = ROUND_DROP_BITS - SCALE_UNITY + int'(s);
        bias = 26'(1) <<< (rs - 1);
        if (xs < 0) begin
            bias = bias - 26'sd1;
        end
        sum = (xs + bias) >>> rs;
        if (sum > 26'sd32767) begin
            round16 = 16'h7fff;
        end else if (sum < -26'sd32768) begin
            round16 = 16'h8000;
        end else begin
            round16 = sum[15:0];
        end
    endfunction

    always_comb begin
        case (fmt)
            // wide words bypass the scale value
            OFS_FMT_24: nxt_out_word = {8'h00, 24'(signed'(in_word))};
            OFS_FMT_32: nxt_out_word = 32'(signed'(in_word));
            default: nxt_out_word = {16'h0000, round16(in_word, scale)};
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_ff <= 1'b0;
            out_word_ff <= '0;
        end else begin
            out_valid_ff <= in_valid;
            if (in_valid) begin
                out_word_ff <= nxt_out_word;
            end
        end
    end

    assign out_valid = out_valid_ff;
    assign out_word = out_word_ff;
endmodule
`default_nettype wire

/* logic/ofs_top.sv */
// fir output scaling, coefficient sequencing and decimation sync
`default_nettype none
module ofs_top
    import ofs_pkg::*;
#(
    parameter int ADDR_W = APB_ADDR_W
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // fir result from the mac datapath
    input wire logic fir_result_valid,
    input wire logic [ofs_pkg::FIR_RESULT_W-1:0] fir_result_word,
    // port word to the output port
    output logic port_output_valid,
    output logic [ofs_pkg::PORT_WORD_W-1:0] port_output_word,
    // coefficient step to the mac datapath
    output ofs_pkg::ofs_coef_step_t coef_step,
    // decimation strobes to the comb stages and fir stage
    output logic comb_decimate,
    output logic fir_decimate,
    // sync pads
    input wire ofs_pkg::ofs_sync_pins_t sync_pad_in,
    output ofs_pkg::ofs_sync_pins_t sync_pad_out,
    output ofs_pkg::ofs_sync_pins_t sync_pad_oe
);
    import ofs_pkg::*;

    if (ADDR_W < APB_ADDR_W) begin : g_chk
        $error("ofs_top: ADDR_W cannot reach the register map");
    end

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_RUN = 2'b10
    } ofs_seq_state_t;

    // register file
    logic [3:0] mode_control_ff;
    logic [3:0] output_scale_control_ff;
    logic [7:0] coefficient_start_offset_ff;
    logic [7:0] comb_two_decimation_ff;
    logic [7:0] comb_five_decimation_ff;
    logic [7:0] fir_decimation_ff;
    logic [7:0] tap_count_ff;
    logic [1:0] output_format_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic [11:0] reg_index;
    logic setup_phase;
    logic wr_en;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;
    logic soft_reset;
    logic sync_master;
    logic dual_channel;
    logic unique_b;

    // sync path
    logic [1:0] comb_sync_sr_ff;
    logic [1:0] fir_sync_sr_ff;
    logic comb_sync_old_ff;
    logic fir_sync_old_ff;
    logic comb_rise;
    logic fir_rise;
    ofs_sync_pins_t sync_out_ff;
    ofs_sync_pins_t sync_oe_ff;
    logic comb_decimate_ff;
    logic fir_decimate_ff;
    logic [15:0] comb_period_m1;
    logic [15:0] comb_count;
    logic [15:0] comb_load_val;
    logic [7:0] fir_count;
    logic [7:0] fir_load_val;
    logic comb_tick;
    logic fir_at_zero;
    logic fir_tick;

    // sequencer
    ofs_seq_state_t seq_state_ff;
    ofs_seq_state_t nxt_seq_state;
    logic [8:0] step_ff;
    logic [8:0] step_last;
    logic [7:0] addr_ff;
    logic chan_b_ff;
    ofs_coef_step_t coef_step_ff;

    // value lat mod m, m at least one; lat is small so a short loop suffices
    function automatic logic [15:0] lat_mod(input logic [15:0] lat, input logic [15:0] m);
        logic [15:0] r;
        r = lat;
        for (int i = 0; i < SYNC_LAT + 1; i++) begin
            if (r >= m) begin
                r = r - m;
            end
        end
        lat_mod = r;
    endfunction

    // ---------------- apb slave ----------------
    assign reg_index = paddr[13:2];
    assign setup_phase = psel && !penable;
    assign wr_en = psel && penable && pwrite && !pslverr_ff;
    assign soft_reset = mode_control_ff[MODE_SOFT_RESET_BIT];
    assign sync_master = mode_control_ff[MODE_SYNC_MASTER_BIT];
    assign dual_channel = mode_control_ff[MODE_DUAL_CHANNEL_BIT];
    assign unique_b = output_scale_control_ff[UNIQUE_B_BIT];

    always_comb begin
        nxt_pslverr = 1'b0;
        nxt_prdata = 32'h0000_0000;
        case (reg_index)
            REG_MODE_CONTROL: nxt_prdata = {28'h000_0000, mode_control_ff};
            REG_COMB_TWO_DECIMATION: nxt_prdata = {24'h00_0000, comb_two_decimation_ff};
            REG_COMB_FIVE_DECIMATION: nxt_prdata = {24'h00_0000, comb_five_decimation_ff};
            REG_OUTPUT_SCALE_CONTROL: nxt_prdata = {28'h000_0000, output_scale_control_ff};
            REG_FIR_DECIMATION: nxt_prdata = {24'h00_0000, fir_decimation_ff};
            REG_COEFFICIENT_START_OFFSET: nxt_prdata = {24'h00_0000, coefficient_start_offset_ff};
            REG_TAP_COUNT: nxt_prdata = {24'h00_0000, tap_count_ff};
            REG_OUTPUT_FORMAT: nxt_prdata = {30'h0000_0000, output_format_ff};
            REG_BLOCK_STATUS: begin
                nxt_prdata = {20'h0_0000, seq_state_ff == SEQ_RUN, chan_b_ff, sync_master, soft_reset, addr_ff};
                nxt_pslverr = pwrite;
            end
            default: nxt_pslverr = 1'b1;
        endcase
        if (paddr[1:0] != 2'b00 || (paddr >> 14) != '0) begin
            nxt_pslverr = 1'b1;
            nxt_prdata = 32'h0000_0000;
        end
    end

    // answer prepared in setup, so the access phase completes at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (setup_phase) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_control_ff <= MODE_CONTROL_RESET;
            output_scale_control_ff <= OUTPUT_SCALE_RESET;
            coefficient_start_offset_ff <= BYTE_REG_RESET;
            comb_two_decimation_ff <= BYTE_REG_RESET;
            comb_five_decimation_ff <= BYTE_REG_RESET;
            fir_decimation_ff <= BYTE_REG_RESET;
            tap_count_ff <= BYTE_REG_RESET;
            output_format_ff <= OUTPUT_FORMAT_RESET;
        end else if (wr_en) begin
            case (reg_index)
                // sync master select lives in mode control
                REG_MODE_CONTROL: mode_control_ff <= pwdata[3:0];
                REG_COMB_TWO_DECIMATION: comb_two_decimation_ff <= pwdata[7:0];
                REG_COMB_FIVE_DECIMATION: comb_five_decimation_ff <= pwdata[7:0];
                // scale in bits 2:0, per-channel flag in bit 3
                REG_OUTPUT_SCALE_CONTROL: output_scale_control_ff <= pwdata[3:0];
                REG_FIR_DECIMATION: fir_decimation_ff <= pwdata[7:0];
                REG_COEFFICIENT_START_OFFSET: coefficient_start_offset_ff <= pwdata[7:0];
                REG_TAP_COUNT: tap_count_ff <= pwdata[7:0];
                REG_OUTPUT_FORMAT: output_format_ff <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // ---------------- sync pads ----------------
    // pads sampled through two flops in either role
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comb_sync_sr_ff <= 2'b00;
            fir_sync_sr_ff <= 2'b00;
            comb_sync_old_ff <= 1'b0;
            fir_sync_old_ff <= 1'b0;
        end else begin
            comb_sync_sr_ff <= {comb_sync_sr_ff[0], sync_pad_in.comb};
            fir_sync_sr_ff <= {fir_sync_sr_ff[0], sync_pad_in.fir};
            comb_sync_old_ff <= comb_sync_sr_ff[1];
            fir_sync_old_ff <= fir_sync_sr_ff[1];
        end
    end

    // each pin realigns its own counter independently
    assign comb_rise = comb_sync_sr_ff[1] && !comb_sync_old_ff;
    assign fir_rise = fir_sync_sr_ff[1] && !fir_sync_old_ff;

    // comb period is the product of both comb factors
    assign comb_period_m1 = 16'((17'(comb_two_decimation_ff) + 17'd1) * (17'(comb_five_decimation_ff) + 17'd1) - 17'd1);
    // phase the master would have reached since the pulse left its pad
    assign comb_load_val = lat_mod(16'(SYNC_LAT), comb_period_m1 + 16'd1);
    // 17 bits so a 65536-cycle period cannot divide by zero
    assign fir_load_val = 8'(lat_mod(16'(17'(SYNC_LAT - 1) / (17'(comb_period_m1) + 17'd1)) + 16'd1,
                                     16'(fir_decimation_ff) + 16'd1));

    // counters free-run at the programmed ratio
    ofs_phase_cnt #(
        .W(16)
    ) u_comb_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .hold(soft_reset),
        .advance(1'b1),
        .last(comb_period_m1),
        .load(comb_rise),
        .load_val(comb_load_val),
        .count(comb_count),
        .at_zero(comb_tick)
    );

    ofs_phase_cnt #(
        .W(8)
    ) u_fir_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .hold(soft_reset),
        .advance(comb_tick),
        .last(fir_decimation_ff),
        .load(fir_rise),
        .load_val(fir_load_val),
        .count(fir_count),
        .at_zero(fir_at_zero)
    );

    // fir pulse only on a comb pulse
    assign fir_tick = comb_tick && fir_at_zero && !soft_reset;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_out_ff <= '0;
            sync_oe_ff <= '0;
            comb_decimate_ff <= 1'b0;
            fir_decimate_ff <= 1'b0;
        end else begin
            // pulses launched from a clock edge
            sync_out_ff.comb <= comb_tick && !soft_reset;
            sync_out_ff.fir <= fir_tick;
            sync_oe_ff.comb <= sync_master;
            sync_oe_ff.fir <= sync_master;
            comb_decimate_ff <= comb_tick && !soft_reset;
            fir_decimate_ff <= fir_tick;
        end
    end

    // ---------------- coefficient sequencer ----------------
    assign step_last = dual_channel ? {tap_count_ff, 1'b1} : {1'b0, tap_count_ff};

    always_comb begin
        nxt_seq_state = seq_state_ff;
        case (seq_state_ff)
            SEQ_IDLE: if (fir_tick) nxt_seq_state = SEQ_RUN;
            SEQ_RUN: if (soft_reset || (step_ff == step_last && !fir_tick)) nxt_seq_state = SEQ_IDLE;
            default: nxt_seq_state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_state_ff <= SEQ_IDLE;
            step_ff <= 9'h000;
            addr_ff <= 8'h00;
            chan_b_ff <= 1'b0;
        end else begin
            seq_state_ff <= nxt_seq_state;
            if (fir_tick) begin
                // each computation opens at the start offset
                step_ff <= 9'h000;
                addr_ff <= coefficient_start_offset_ff;
                chan_b_ff <= 1'b0;
            end else if (seq_state_ff == SEQ_RUN) begin
                step_ff <= step_ff + 9'h001;
                chan_b_ff <= dual_channel && !chan_b_ff;
                if (!dual_channel || unique_b) begin
                    // single channel or per-channel sets, index moves every step
                    addr_ff <= addr_ff + 8'h01;
                end else if (chan_b_ff) begin
                    // shared set, index moves after channel b
                    addr_ff <= addr_ff + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coef_step_ff <= '0;
        end else begin
            coef_step_ff.valid <= seq_state_ff == SEQ_RUN && !soft_reset;
            coef_step_ff.chan_b <= chan_b_ff;
            coef_step_ff.first <= step_ff == 9'h000;
            coef_step_ff.last <= step_ff == step_last;
            coef_step_ff.addr <= addr_ff;
        end
    end

    // ---------------- output scaling ----------------
    // scale value steers the 16-bit path only
    ofs_scaler u_scaler (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(fir_result_valid && !soft_reset),
        .in_word(fir_result_word),
        .scale(output_scale_control_ff[SCALE_LSB +: SCALE_W]),
        .fmt(ofs_fmt_t'(output_format_ff)),
        .out_valid(port_output_valid),
        .out_word(port_output_word)
    );

    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = pslverr_ff;
    assign coef_step = coef_step_ff;
    assign comb_decimate = comb_decimate_ff;
    assign fir_decimate = fir_decimate_ff;
    assign sync_pad_out = sync_out_ff;
    assign sync_pad_oe = sync_oe_ff;
endmodule
`default_nettype wire

/* dv/ofs_top_props.sv */
// port assertions for the fir output scale and sync block
`default_nettype none
module ofs_top_props
    import ofs_pkg::*;
#(
    parameter int ADDR_W = 14
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // datapath
    input wire logic fir_result_valid,
    input wire logic [ofs_pkg::FIR_RESULT_W-1:0] fir_result_word,
    input wire logic port_output_valid,
    input wire logic [ofs_pkg::PORT_WORD_W-1:0] port_output_word,
    input wire ofs_pkg::ofs_coef_step_t coef_step,
    input wire logic comb_decimate,
    input wire logic fir_decimate,
    // pads
    input wire ofs_pkg::ofs_sync_pins_t sync_pad_in,
    input wire ofs_pkg::ofs_sync_pins_t sync_pad_out,
    input wire ofs_pkg::ofs_sync_pins_t sync_pad_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_fir_with_comb: assert property (fir_decimate |-> comb_decimate)
        else $error("fir strobe without comb strobe");
    a_pad_fir_comb: assert property (sync_pad_out.fir |-> sync_pad_out.comb)
        else $error("fir pad pulse without comb pad pulse");
    a_pad_with_strobe: assert property (sync_pad_out.comb |-> comb_decimate)
        else $error("comb pad pulse off the comb strobe");
    a_oe_paired: assert property (sync_pad_oe.comb == sync_pad_oe.fir)
        else $error("pad enables differ");
    a_scaled_cause: assert property (port_output_valid |-> $past(fir_result_valid))
        else $error("port word without a fir result");
    a_first_step: assert property (coef_step.valid && coef_step.first |-> $past(fir_decimate))
        else $error("first coefficient step not after fir strobe");
    a_steps_unbroken: assert property (coef_step.valid && !coef_step.last |=> coef_step.valid)
        else $error("coefficient sequence broken");
    a_err_reads_zero: assert property (pslverr |-> prdata == 32'h0000_0000)
        else $error("refused read returns data");
    a_ready_high: assert property (psel && penable |-> pready)
        else $error("access phase stalled");
    c_fir_tick: cover property (fir_decimate);
    c_seq_end: cover property (coef_step.valid && coef_step.last);
    c_refused: cover property (pslverr);
    c_master: cover property (sync_pad_oe.comb && comb_decimate);
endmodule
bind ofs_top ofs_top_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fir_result_valid(fir_result_valid), .fir_result_word(fir_result_word),
    .port_output_valid(port_output_valid), .port_output_word(port_output_word), .coef_step(coef_step),
    .comb_decimate(comb_decimate), .fir_decimate(fir_decimate), .sync_pad_in(sync_pad_in),
    .sync_pad_out(sync_pad_out), .sync_pad_oe(sync_pad_oe));
`default_nettype wire

/* dv/ofs_sync_peer.sv */
// peer receiver model driving comb and fir sync pulses
`default_nettype none
module ofs_sync_peer #(
    parameter int P = 3,
    parameter int F = 3
) (
    // clock
    input wire logic pclk,
    // control
    input wire logic en,
    input wire logic [7:0] phase,
    // pad drive
    output logic comb,
    output logic fir
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    int nc = 0;
    always @(posedge pclk) begin
        if (!en) begin
            cnt <= phase;
            nc <= 0;
            comb <= 1'b0;
            fir <= 1'b0;
        end else begin
            cnt <= (cnt == P - 1) ? 0 : cnt + 1;
            comb <= (cnt == 0);
            fir <= (cnt == 0) && (nc == 0);
            if (cnt == 0) nc <= (nc == F - 1) ? 0 : nc + 1;
        end
    end
endmodule
`default_nettype wire

/* dv/fir_output_scale_and_sync_tb.sv */
// self-checking bench for the fir output scale and sync block
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module fir_output_scale_and_sync_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ofs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fir_result_valid = 0;
    logic [13:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, port_output_word;
    logic [22:0] fir_result_word = '0;
    logic pready, pslverr, port_output_valid, comb_decimate, fir_decimate, peer_en = 0, peer_comb, peer_fir;
    logic [7:0] peer_phase = '0;
    ofs_coef_step_t coef_step;
    ofs_sync_pins_t pad_in, sync_pad_out, sync_pad_oe;
    int n_fail = 0, n_tests = 0;
    // released pads are pulled low
    assign pad_in.comb = sync_pad_oe.comb ? sync_pad_out.comb : peer_en & peer_comb;
    assign pad_in.fir = sync_pad_oe.fir ? sync_pad_out.fir : peer_en & peer_fir;
    ofs_top u_ofs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fir_result_valid(fir_result_valid), .fir_result_word(fir_result_word),
        .port_output_valid(port_output_valid), .port_output_word(port_output_word), .coef_step(coef_step),
        .comb_decimate(comb_decimate), .fir_decimate(fir_decimate), .sync_pad_in(pad_in),
        .sync_pad_out(sync_pad_out), .sync_pad_oe(sync_pad_oe));
    ofs_sync_peer u_ofs_sync_peer (.pclk(pclk), .en(peer_en), .phase(peer_phase), .comb(peer_comb),
        .fir(peer_fir));
    task results;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task tmo;
        n_fail++;
        $display("MISMATCH wait exp done got timeout");
        results();
    endtask
    task apb(input bit w, input logic [11:0] idx, input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n == 20) tmo();
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [11:0] idx, input int d);
        logic [31:0] r;
        logic e;
        apb(1, idx, 32'(d), r, e);
        `CHK("write err", 1'b0, e)
    endtask
    task rd_chk(input logic [11:0] idx, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(0, idx, 32'h0000_0000, r, e);
        `CHK("rdata", x, r)
        `CHK("rd err", xe, e)
    endtask
    function automatic logic [31:0] exp_word(int x, int s, int f);
        int d, q;
        if (f == 1) return x & 32'h00ff_ffff;
        if (f == 2) return x;
        d = 3 + s;
        q = ((x < 0 ? -x : x) + (1 << (d - 1))) >>> d;
        if (x < 0) q = -q;
        if (q > 32'sh0000_7fff) q = 32'sh0000_7fff;
        if (q < -32'sh0000_8000) q = -32'sh0000_8000;
        return q & 32'h0000_ffff;
    endfunction
    task scale_one(input int x, input int s, input int f);
        @(posedge pclk);
        fir_result_valid <= 1;
        fir_result_word <= x[22:0];
        @(posedge pclk);
        fir_result_valid <= 0;
        @(negedge pclk);
        `CHK("out valid", 1'b1, port_output_valid)
        `CHK("out word", exp_word(x, s, f), port_output_word)
    endtask
    task seq_chk(input int off, input int n, input int md);
        int k, ea, st;
        st = md == 0 ? n : 2 * n;
        repeat (20) @(negedge pclk);
        k = 0;
        while (!(coef_step.valid === 1'b1 && coef_step.first === 1'b1) && k < 40) begin
            @(negedge pclk);
            k++;
        end
        if (k == 40) tmo();
        for (int i = 0; i < st; i++) begin
            ea = md == 1 ? off + i / 2 : off + i;
            `CHK("coef addr", ea[7:0], coef_step.addr)
            `CHK("coef chan", md != 0 && i % 2 == 1, coef_step.chan_b)
            `CHK("coef last", i == st - 1, coef_step.last)
            @(negedge pclk);
        end
    endtask
    task sync_run(input logic oe, input bit slave);
        int lc, lf;
        lc = -1;
        lf = -1;
        repeat (30) @(negedge pclk);
        for (int t = 0; t < 45; t++) begin
            @(negedge pclk);
            if (comb_decimate === 1'b1) begin
                if (lc >= 0) `CHK("comb gap", 3, t - lc)
                `CHK("comb phase", 1'b1, slave ? pad_in.comb : sync_pad_out.comb)
                lc = t;
            end
            if (fir_decimate === 1'b1) begin
                if (lf >= 0) `CHK("fir gap", 9, t - lf)
                `CHK("fir phase", 1'b1, slave ? pad_in.fir : sync_pad_out.fir)
                lf = t;
            end
        end
        `CHK("pulses seen", 1'b1, lc >= 0 && lf >= 0)
        `CHK("pad oe", {2{oe}}, sync_pad_oe)
    endtask
    initial begin
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        tmo();
    end
    initial begin
        int x;
        logic [31:0] r;
        logic e;
        int vals[6] = '{32'hffc0_0000, 32'h003f_ffff, 0, 32'h0000_0040, 32'hffff_ffc0, 32'h0000_00c0};
        void'($urandom(36));
        repeat (16) @(posedge pclk);
        presetn <= 1;
        rd_chk(REG_MODE_CONTROL, {28'h0, MODE_CONTROL_RESET}, 0);
        rd_chk(REG_OUTPUT_SCALE_CONTROL, {28'h0, OUTPUT_SCALE_RESET}, 0);
        rd_chk(REG_COEFFICIENT_START_OFFSET, {24'h0, BYTE_REG_RESET}, 0);
        rd_chk(12'h0301, 32'h0000_0000, 1);
        apb(1, REG_BLOCK_STATUS, 32'h0000_0fff, r, e);
        `CHK("status write err", 1'b1, e)
        $display("test registers done");
        wr(REG_COMB_TWO_DECIMATION, 2);
        wr(REG_COMB_FIVE_DECIMATION, 0);
        wr(REG_FIR_DECIMATION, 2);
        wr(REG_TAP_COUNT, 1);
        wr(REG_COEFFICIENT_START_OFFSET, 5);
        wr(REG_MODE_CONTROL, 0);
        for (int f = 0; f < 4; f++) begin
            wr(REG_OUTPUT_FORMAT, f);
            for (int s = 0; s < 8; s++) begin
                wr(REG_OUTPUT_SCALE_CONTROL, s);
                for (int j = 0; j < 8; j++) begin
                    x = j < 6 ? vals[j] : int'($urandom_range(0, 32'h007f_ffff)) - 32'sh0040_0000;
                    scale_one(x, s, f);
                end
            end
        end
        $display("test scaling done");
        seq_chk(5, 2, 0);
        wr(REG_COEFFICIENT_START_OFFSET, 9);
        seq_chk(9, 2, 0);
        wr(REG_MODE_CONTROL, 2);
        seq_chk(9, 2, 1);
        wr(REG_OUTPUT_SCALE_CONTROL, 8);
        wr(REG_COEFFICIENT_START_OFFSET, 4);
        rd_chk(REG_OUTPUT_SCALE_CONTROL, 32'h0000_0008, 0);
        seq_chk(4, 2, 2);
        $display("test sequencing done");
        wr(REG_MODE_CONTROL, 8);
        sync_run(1, 0);
        wr(REG_MODE_CONTROL, 0);
        peer_phase <= 8'($urandom_range(0, 2));
        peer_en <= 1;
        sync_run(0, 1);
        $display("test sync done");
        results();
    end
endmodule
`default_nettype wire
